// ===== rtl/ovs_setpoint.sv
// Output voltage format and target registers with boot, restore, clamp and slew
`default_nettype none
module ovs_setpoint #(
   parameter int TICK_CYC = ovs_pkg::SLEW_TICK_CYC
) (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // Command transactions from the bus decoder
   input wire ovs_pkg::ovs_req_s i_req,
   output ovs_pkg::ovs_rsp_s o_rsp,
   // Converter state and settings
   input wire logic i_conv_enable,
   input wire logic [15:0] i_trim,
   input wire logic [15:0] i_vout_max,
   input wire logic [15:0] i_vout_min,
   input wire logic [15:0] i_slew_step,
   // Boot sources and misc_option_config
   input wire logic [7:0] i_nvm_format,
   input wire logic [15:0] i_nvm_target,
   input wire logic [15:0] i_voltage_select_strap,
   input wire logic i_strap_source_override,
   input wire logic i_fault_reboot_select,
   input wire logic i_reset_pin_mode,
   input wire logic i_power_good_reset_pin_n,
   input wire logic i_restore_user,
   input wire logic i_fault_restart,
   // Results
   output logic [7:0] o_format,
   output logic [15:0] o_target,
   output logic [15:0] o_boot_voltage,
   output logic [15:0] o_dac,
   output ovs_pkg::ovs_evt_s o_evt
);
   ovs_pkg::ovs_state_e state;
   logic [7:0] format;
   logic [15:0] target;
   logic [15:0] boot_voltage;
   logic [15:0] dac;
   logic [$clog2(TICK_CYC+1)-1:0] tick_cnt;
   ovs_pkg::ovs_rsp_s rsp;
   ovs_pkg::ovs_evt_s evt;

   // Shift a mantissa from one exponent to another
   function automatic logic [15:0] rescale(input logic [15:0] v, input logic [4:0] oe,
                                           input logic [4:0] ne);
      logic signed [5:0] d;
      logic [5:0] nd;
      d = $signed({oe[4], oe}) - $signed({ne[4], ne});
      nd = 6'(-d);
      if (d >= 0) begin
         rescale = v << d[3:0];
      end else begin
         rescale = v >> nd[3:0];
      end
   endfunction

   // Command decode
   wire is_fmt = i_req.code == ovs_pkg::CMD_FORMAT;
   wire is_tgt = i_req.code == ovs_pkg::CMD_TARGET;
   wire wr = i_req.valid & i_req.write & (state == ovs_pkg::ST_RUN);
   wire [4:0] new_exp = i_req.data[ovs_pkg::EXP_HI:0];
   wire [4:0] cur_exp = format[ovs_pkg::EXP_HI:0];
   wire exp_ok = ($signed(new_exp) <= $signed(ovs_pkg::EXP_COARSE)) &&
                 ($signed(new_exp) >= $signed(ovs_pkg::EXP_FINE));
   wire fmt_wr = wr & is_fmt & ~i_conv_enable & exp_ok;
   wire tgt_wr = wr & is_tgt;
   wire bad_wr = i_req.valid & i_req.write & ~fmt_wr & ~tgt_wr;
   wire bad_rd = i_req.valid & ~i_req.write & ~is_fmt & ~is_tgt;
   // Mode bits forced to linear whatever the host writes
   wire [7:0] next_format = {i_req.data[ovs_pkg::REL_BIT], ovs_pkg::MODE_LINEAR,
                             new_exp};

   // Event sources
   wire pin_reset = i_reset_pin_mode & ~i_power_good_reset_pin_n;
   wire restore = (state == ovs_pkg::ST_BOOT) | i_restore_user;
   wire [15:0] src_target = i_strap_source_override ? i_voltage_select_strap
                                                    : i_nvm_target;
   wire fault_boot = i_fault_restart & i_fault_reboot_select;

   // Limit check on target plus trim
   wire [17:0] trim_ext = {{2{i_trim[15]}}, i_trim};
   wire [17:0] max_ext = {2'h0, i_vout_max};
   wire [17:0] min_ext = {2'h0, i_vout_min};
   wire [17:0] sum_cur = {2'h0, target} + trim_ext;
   wire [17:0] sum_wr = {2'h0, i_req.data} + trim_ext;
   wire hi_cur = $signed(sum_cur) > $signed(max_ext);
   wire lo_cur = $signed(sum_cur) < $signed(min_ext);
   wire viol_wr = ($signed(sum_wr) > $signed(max_ext)) | ($signed(sum_wr) < $signed(min_ext));
   wire [15:0] goal = hi_cur ? i_vout_max : lo_cur ? i_vout_min : sum_cur[15:0];
   wire limit_evt = tgt_wr & ~restore & ~pin_reset & ~fault_boot & viol_wr;

   // Target selection, highest priority first
   wire [15:0] next_target = restore ? src_target :
                             (pin_reset | fault_boot) ? boot_voltage :
                             fmt_wr ? rescale(target, cur_exp, new_exp) :
                             tgt_wr ? i_req.data : target;
   wire [15:0] next_boot = restore ? src_target :
                           fmt_wr ? rescale(boot_voltage, cur_exp, new_exp) : boot_voltage;
   wire [7:0] next_fmt_reg = (state == ovs_pkg::ST_BOOT) ?
                             {i_nvm_format[ovs_pkg::REL_BIT], ovs_pkg::MODE_LINEAR,
                              i_nvm_format[ovs_pkg::EXP_HI:0]} :
                             fmt_wr ? next_format : format;

   // Slew limited DAC step
   wire tick = tick_cnt == '0;
   wire [15:0] gap = (goal > dac) ? goal - dac : dac - goal;
   wire [15:0] next_dac = (gap <= i_slew_step) ? goal :
                          (goal > dac) ? dac + i_slew_step : dac - i_slew_step;

   // Read mux
   wire [15:0] rd_data = is_fmt ? {8'h00, format} : is_tgt ? target : 16'h0000;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         state <= ovs_pkg::ST_BOOT;
      end else begin
         state <= ovs_pkg::ST_RUN;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         format <= ovs_pkg::FMT_RESET;
         target <= ovs_pkg::TARGET_RESET;
         boot_voltage <= ovs_pkg::TARGET_RESET;
      end else begin
         format <= next_fmt_reg;
         target <= next_target;
         boot_voltage <= next_boot;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         tick_cnt <= '0;
         dac <= ovs_pkg::TARGET_RESET;
      end else begin
         tick_cnt <= tick ? ($bits(tick_cnt))'(TICK_CYC - 1) : tick_cnt - 1'b1;
         if (tick) begin
            dac <= next_dac;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         rsp <= '0;
         evt <= '0;
      end else begin
         rsp.valid <= i_req.valid;
         rsp.nack <= bad_wr | bad_rd;
         rsp.data <= i_req.write ? 16'h0000 : rd_data;
         evt <= {4{limit_evt}};
      end
   end

   assign o_format = format;
   assign o_target = target;
   assign o_boot_voltage = boot_voltage;
   assign o_dac = dac;
   assign o_rsp = rsp;
   assign o_evt = evt;

   // Checks
   sequence s_run_fmt_wr;
      wr && is_fmt;
   endsequence

   sequence s_plain;
      !restore && !pin_reset && !fault_boot;
   endsequence

   a_fmt_lock_conv: assert property (@(posedge i_clock) disable iff (i_rst)
      s_run_fmt_wr and i_conv_enable |=> $stable(format))
      else $error("format changed while converting");

   a_mode_linear: assert property (@(posedge i_clock) disable iff (i_rst)
      format[ovs_pkg::MODE_HI:ovs_pkg::MODE_LO] == ovs_pkg::MODE_LINEAR)
      else $error("mode bits not linear");

   a_exp_range: assert property (@(posedge i_clock) disable iff (i_rst)
      state == ovs_pkg::ST_RUN && !$past(state == ovs_pkg::ST_BOOT) |->
      $signed(cur_exp) >= -12 && $signed(cur_exp) <= -4)
      else $error("exponent out of range");

   a_fmt_rescale: assert property (@(posedge i_clock) disable iff (i_rst)
      s_run_fmt_wr and s_plain and !i_conv_enable and exp_ok and
      new_exp == cur_exp |=> $stable(target))
      else $error("target moved on same exponent");

   a_tgt_write: assert property (@(posedge i_clock) disable iff (i_rst)
      tgt_wr and s_plain |=> target == $past(i_req.data))
      else $error("target write lost");

   a_pin_boot: assert property (@(posedge i_clock) disable iff (i_rst)
      pin_reset && !restore |=> target == $past(boot_voltage))
      else $error("pin reset did not restore boot");

   a_fault_keep: assert property (@(posedge i_clock) disable iff (i_rst)
      i_fault_restart && !i_fault_reboot_select && !restore && !pin_reset &&
      !(i_req.valid && i_req.write) |=> $stable(target))
      else $error("target changed on hiccup");

   a_restore_src: assert property (@(posedge i_clock) disable iff (i_rst)
      i_restore_user |=> boot_voltage == $past(src_target) && target == boot_voltage)
      else $error("restore source wrong");

   a_limit_warn: assert property (@(posedge i_clock) disable iff (i_rst)
      tgt_wr and s_plain and viol_wr |=> o_evt.warning && o_evt.alert)
      else $error("limit warning missing");

   a_dac_clamp: assert property (@(posedge i_clock) disable iff (i_rst)
      hi_cur |-> goal == i_vout_max)
      else $error("goal above max");

   a_slew_step: assert property (@(posedge i_clock) disable iff (i_rst)
      tick && gap > i_slew_step |=> (dac > $past(dac) ? dac - $past(dac)
                                    : $past(dac) - dac) == $past(i_slew_step))
      else $error("dac stepped beyond slew");

   // Register writes and read back
   a_fmt_write_lands: assert property (@(posedge i_clock) disable iff (i_rst)
      fmt_wr
      |=> format == $past(next_format))
      else $error("format write lost");

   a_rel_stored: assert property (@(posedge i_clock) disable iff (i_rst)
      fmt_wr
      |=> format[ovs_pkg::REL_BIT] == $past(i_req.data[ovs_pkg::REL_BIT]))
      else $error("relative select not stored");

   a_mode_ignored: assert property (@(posedge i_clock) disable iff (i_rst)
      i_req.valid && i_req.write && is_fmt
      |=> format[ovs_pkg::MODE_HI:ovs_pkg::MODE_LO] == ovs_pkg::MODE_LINEAR)
      else $error("mode bits took a write");

   a_fmt_refused: assert property (@(posedge i_clock) disable iff (i_rst)
      wr && is_fmt && !exp_ok
      |=> $stable(format))
      else $error("bad exponent accepted");

   a_rsp_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
      i_req.valid
      |=> o_rsp.valid)
      else $error("response missing");

   a_rsp_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
      !i_req.valid
      |=> !o_rsp.valid)
      else $error("response without request");

   a_read_word: assert property (@(posedge i_clock) disable iff (i_rst)
      i_req.valid && !i_req.write && is_tgt
      |=> o_rsp.data == $past(target) && !o_rsp.nack)
      else $error("target read wrong");

   a_read_fmt: assert property (@(posedge i_clock) disable iff (i_rst)
      i_req.valid && !i_req.write && is_fmt
      |=> o_rsp.data == {8'h00, $past(format)} && !o_rsp.nack)
      else $error("format read wrong");

   // Boot and restore sources
   a_boot_format: assert property (@(posedge i_clock) disable iff (i_rst)
      state == ovs_pkg::ST_BOOT
      |=> format[ovs_pkg::EXP_HI:0] == $past(i_nvm_format[ovs_pkg::EXP_HI:0]))
      else $error("boot format not loaded");

   a_boot_target: assert property (@(posedge i_clock) disable iff (i_rst)
      state == ovs_pkg::ST_BOOT
      |=> target == $past(src_target) && boot_voltage == $past(src_target))
      else $error("boot target not loaded");

   a_nvm_pick: assert property (@(posedge i_clock) disable iff (i_rst)
      restore && !i_strap_source_override
      |=> target == $past(i_nvm_target))
      else $error("memory source not used");

   a_strap_pick: assert property (@(posedge i_clock) disable iff (i_rst)
      restore && i_strap_source_override
      |=> target == $past(i_voltage_select_strap))
      else $error("strap source not used");

   a_boot_apart: assert property (@(posedge i_clock) disable iff (i_rst)
      !restore && !fmt_wr
      |=> $stable(boot_voltage))
      else $error("boot voltage disturbed");

   a_pin_boot_keep: assert property (@(posedge i_clock) disable iff (i_rst)
      pin_reset && !restore && !fmt_wr
      |=> $stable(boot_voltage))
      else $error("pin reset moved boot voltage");

   a_fault_boot: assert property (@(posedge i_clock) disable iff (i_rst)
      fault_boot && !restore
      |=> target == $past(boot_voltage))
      else $error("fault restart kept target");

   a_tgt_hold: assert property (@(posedge i_clock) disable iff (i_rst)
      !restore && !pin_reset && !fault_boot && !fmt_wr && !tgt_wr
      |=> $stable(target))
      else $error("target changed with no cause");

   // Limits, events and slew
   a_dac_floor: assert property (@(posedge i_clock) disable iff (i_rst)
      lo_cur && !hi_cur
      |-> goal == i_vout_min)
      else $error("goal below min");

   a_evt_all: assert property (@(posedge i_clock) disable iff (i_rst)
      o_evt.warning
      |-> o_evt.status_word_vout && o_evt.status_vout_max_min && o_evt.alert)
      else $error("status bits not raised together");

   a_evt_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
      !(tgt_wr && viol_wr)
      |=> !o_evt.warning)
      else $error("warning without limit write");

   a_dac_hold: assert property (@(posedge i_clock) disable iff (i_rst)
      !tick
      |=> $stable(dac))
      else $error("dac moved between ticks");

   a_dac_settle: assert property (@(posedge i_clock) disable iff (i_rst)
      tick && gap <= i_slew_step
      |=> dac == $past(goal))
      else $error("dac missed close goal");
endmodule // ovs_setpoint
`default_nettype wire

// ===== rtl/ovs_pkg.sv
// Constants and carriers for the output voltage setpoint register bank
`default_nettype none
package ovs_pkg;
   localparam logic [7:0] CMD_FORMAT = 8'h20;
   localparam logic [7:0] CMD_TARGET = 8'h21;
   localparam int REL_BIT = 7;
   localparam int MODE_HI = 6;
   localparam int MODE_LO = 5;
   localparam int EXP_HI = 4;
   localparam logic [1:0] MODE_LINEAR = 2'h0;
   localparam logic [4:0] EXP_COARSE = 5'h1C;
   localparam logic [4:0] EXP_FINE = 5'h14;
   localparam logic [7:0] FMT_RESET = 8'h14;
   localparam logic [15:0] TARGET_RESET = 16'h0000;
   localparam int CLOCK_MHZ = 40;
   localparam int SLEW_TICK_NS = 1000;
   localparam int SLEW_TICK_CYC = SLEW_TICK_NS * CLOCK_MHZ / 1000;

   typedef enum logic [0:0] {
      ST_BOOT = 1'b0,
      ST_RUN = 1'b1
   } ovs_state_e;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] code;
      logic [15:0] data;
   } ovs_req_s;

   typedef struct packed {
      logic valid;
      logic nack;
      logic [15:0] data;
   } ovs_rsp_s;

   typedef struct packed {
      logic warning;
      logic status_word_vout;
      logic status_vout_max_min;
      logic alert;
   } ovs_evt_s;
endpackage
`default_nettype wire

// ===== dv/ovs_host.sv
// Host model issuing word transactions on the command port
`default_nettype none
module ovs_host (
   // Clock
   input wire logic i_clock,
   // Command port
   output var ovs_pkg::ovs_req_s o_req,
   input wire ovs_pkg::ovs_rsp_s i_rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_req = '0;
   // Idle data is inverted so a stale word can never pass for a fresh one
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] d,
      output ovs_pkg::ovs_rsp_s r);
      @(posedge i_clock);
      o_req <= '{valid: 1'b1, write: wr, code: code, data: d};
      @(posedge i_clock);
      o_req <= '{valid: 1'b0, write: wr, code: code, data: ~d};
      #1;
      r = i_rsp;
   endtask
endmodule // ovs_host
`default_nettype wire

// ===== dv/ovs_setpoint_bench.sv
// Self-checking bench for the output voltage setpoint registers
`default_nettype none
module ovs_setpoint_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic conv = 1'b0;
   logic ovr = 1'b0;
   logic flt_sel = 1'b0;
   logic pin_mode = 1'b0;
   logic [2:0] ev = 3'h0;
   logic [15:0] trim = 16'h0000;
   logic [15:0] strap = 16'h0300;
   logic [15:0] nvm_tgt = 16'h0100;
   logic [15:0] tgt, boot, dac;
   logic [7:0] fmt;
   ovs_pkg::ovs_req_s req;
   ovs_pkg::ovs_rsp_s rsp, r;
   ovs_pkg::ovs_evt_s evt;
   // Format write, expected format, rescaled target, refusal
   logic [32:0] ftab [6] = '{{8'hF8, 8'h98, 16'h0050, 1'b0}, {8'h14, 8'h14, 16'h0500, 1'b0},
      {8'h1C, 8'h1C, 16'h0005, 1'b0}, {8'h74, 8'h14, 16'h0500, 1'b0},
      {8'h1D, 8'h14, 16'h0500, 1'b1}, {8'h13, 8'h14, 16'h0500, 1'b1}};
   // Trim, target write, limit event, settled DAC
   logic [48:0] ltab [3] = '{{16'h0080, 16'h0300, 1'b0, 16'h0380},
      {16'h0080, 16'h03C0, 1'b1, 16'h0400}, {16'h0000, 16'h0500, 1'b1, 16'h0400}};
   int error_cnt = 0;
   int check_count = 0;
   always #12.5 i_clock = ~i_clock;
   ovs_host host (.i_clock(i_clock), .o_req(req), .i_rsp(rsp));
   ovs_setpoint #(.TICK_CYC(2)) DUT (.i_clock(i_clock), .i_rst(i_rst), .i_req(req),
      .o_rsp(rsp), .i_conv_enable(conv), .i_trim(trim), .i_vout_max(16'h0400),
      .i_vout_min(16'h0010), .i_slew_step(16'h0040), .i_nvm_format(8'h74),
      .i_nvm_target(nvm_tgt), .i_voltage_select_strap(strap),
      .i_strap_source_override(ovr), .i_fault_reboot_select(flt_sel),
      .i_reset_pin_mode(pin_mode), .i_power_good_reset_pin_n(~ev[2]),
      .i_restore_user(ev[0]), .i_fault_restart(ev[1]), .o_format(fmt), .o_target(tgt),
      .o_boot_voltage(boot), .o_dac(dac), .o_evt(evt));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic wr, input logic [7:0] c, input logic [15:0] d,
      input logic nk, input logic [15:0] exp);
      host.xfer(wr, c, d, r);
      chk({15'h0000, r.valid}, 16'h0001);
      chk({15'h0000, r.nack}, {15'h0000, nk});
      if (!wr) chk(r.data, exp);
   endtask
   task automatic pulse(input int b);
      @(posedge i_clock);
      ev[b] <= 1'b1;
      @(posedge i_clock);
      ev[b] <= 1'b0;
      #1;
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      error_cnt++;
      end_sim();
   end
   initial begin
      repeat (16) @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (60) @(posedge i_clock);
      acc(1'b0, 8'h20, 16'h0000, 1'b0, 16'h0014);
      acc(1'b0, 8'h21, 16'h0000, 1'b0, 16'h0100);
      chk(boot, 16'h0100);
      chk(dac, 16'h0100);
      for (int i = 0; i < 3; i++) begin
         trim <= ltab[i][48:33];
         acc(1'b1, 8'h21, ltab[i][32:17], 1'b0, 16'h0000);
         chk({15'h0000, evt.warning & evt.alert}, {15'h0000, ltab[i][16]});
         chk({15'h0000, evt.status_word_vout & evt.status_vout_max_min},
            {15'h0000, ltab[i][16]});
         repeat (3) @(posedge i_clock);
         if (i == 0 && dac === ltab[i][15:0]) chk(dac, 16'h0100);
         repeat (40) @(posedge i_clock);
         chk(dac, ltab[i][15:0]);
      end
      acc(1'b0, 8'h21, 16'h0000, 1'b0, 16'h0500);
      foreach (ftab[i]) begin
         acc(1'b1, 8'h20, {8'h00, ftab[i][32:25]}, ftab[i][0], 16'h0000);
         acc(1'b0, 8'h20, 16'h0000, 1'b0, {8'h00, ftab[i][24:17]});
         chk(tgt, ftab[i][16:1]);
      end
      conv <= 1'b1;
      acc(1'b1, 8'h20, 16'h0018, 1'b1, 16'h0000);
      chk({8'h00, fmt}, 16'h0014);
      conv <= 1'b0;
      acc(1'b0, 8'h2E, 16'h0000, 1'b1, 16'h0000);
      ovr <= 1'b1;
      pulse(0);
      chk(tgt, 16'h0300);
      acc(1'b1, 8'h21, 16'h0250, 1'b0, 16'h0000);
      chk(boot, 16'h0300);
      pulse(2);
      chk(tgt, 16'h0250);
      pin_mode <= 1'b1;
      pulse(2);
      chk(tgt, 16'h0300);
      acc(1'b1, 8'h21, 16'h0250, 1'b0, 16'h0000);
      pulse(1);
      chk(tgt, 16'h0250);
      flt_sel <= 1'b1;
      pulse(1);
      chk(tgt, 16'h0300);
      ovr <= 1'b0;
      pulse(0);
      chk(tgt, 16'h0100);
      end_sim();
   end
endmodule // ovs_setpoint_bench
`default_nettype wire
